/* File: src/fswd_pkg.sv */
// Shared constants of the fail-safe watchdog timer
package fswd_pkg;
  // ==========================================================
  // Widths and prescaler factors
  localparam int          CNT_W      = 16;
  localparam int          PRE_W      = 14;
  localparam int          DIV_SLOW   = 16384;
  localparam int          DIV_FAST   = 256;
  localparam logic        SEL_SLOW   = 1'b0;
  localparam logic        SEL_FAST   = 1'b1;
  // ==========================================================
  // Reset values and counter maximum
  localparam logic [15:0] RELOAD_RST = 16'hff00;
  localparam logic        SEL_RST    = SEL_FAST;
  localparam logic [15:0] CNT_MAX    = 16'hffff;
  // ==========================================================
  // Timing at the 10 MHz system clock
  localparam int          CLK_NS          = 100;
  localparam int          DEF_TIMEOUT_NS  = 6_500_000;
  localparam int          DEF_TIMEOUT_CYC = DEF_TIMEOUT_NS / CLK_NS;
  // Span of intervals: one fast tick up to 2^16 slow ticks
  localparam longint      MIN_INTERVAL_CYC = DIV_FAST;
  localparam longint      MAX_INTERVAL_CYC = longint'(DIV_SLOW) * 65536;
  localparam int          F80_MHZ          = 80;
  localparam int          F100_MHZ         = 100;
  // ==========================================================
  // Failure response states
  typedef enum logic [1:0] {
    FSWD_RUN     = 2'b00,
    FSWD_PREWARN = 2'b01,
    FSWD_RESET   = 2'b10
  } fswd_state_e;
endpackage

/* File: src/fswd_tick_if.sv */
// Link between watchdog core and its prescaler
`timescale 1ns/10ps
interface fswd_tick_if;
  logic                       run;
  logic                       clear;
  logic                       sel;
  logic                       tick;
  logic [fswd_pkg::PRE_W-1:0] count;
  modport core (output run, output clear, output sel, input tick, input count);
  modport pre  (input run, input clear, input sel, output tick, output count);
endinterface

/* File: src/fswd_prescaler.sv */
// Selectable divide-by-16384 or divide-by-256 prescaler
`timescale 1ns/10ps
module fswd_prescaler (
  input  wire logic clk_i,    // System clock
  input  wire logic rst_n_i,  // Synchronous reset, active low
  fswd_tick_if.pre  tk        // Link to watchdog core
);
  logic [fswd_pkg::PRE_W-1:0] pre_reg;
  logic [fswd_pkg::PRE_W-1:0] last;

  // ==========================================================
  // Terminal count per selected factor
  assign last = (tk.sel == fswd_pkg::SEL_FAST) ?
                fswd_pkg::PRE_W'(fswd_pkg::DIV_FAST - 1) :
                fswd_pkg::PRE_W'(fswd_pkg::DIV_SLOW - 1);
  assign tk.tick  = tk.run && !tk.clear && (pre_reg >= last); // [R5]
  assign tk.count = pre_reg;

  always_ff @(posedge clk_i) begin
    if (!rst_n_i) begin
      pre_reg <= '0;
    end else if (tk.clear) begin
      pre_reg <= '0; // [R7]
    end else if (tk.run) begin
      pre_reg <= tk.tick ? '0 : pre_reg + 1'b1; // [R5]
    end
  end
endmodule

/* File: src/fswd_watchdog.sv */
// Fail-safe watchdog timer core with prewarning and reset request
// Notes on behaviour
// [R1] - Enabled and counting after every reset
// [R2] - Disable and enable instructions act anytime
// [R3] - Software services before overflow
// [R4] - Overflow raises prewarning, then reset request
// [R5] - 16-bit counter, clock divided 16384/256
// [R6] - Counter loads from programmable reload value
// [R7] - Service reloads counter and clears prescaler
// [R8] - 3.2 us to 13.4 s at 80 MHz
// [R9] - 2.56 us to 10.74 s at 100 MHz
// [R10] - Default timeout 6.5 ms at 10 MHz
// [R11] - Counts up, overflows past all-ones
// [R12] - Disabled: hold counts, no failure response
`timescale 1ns/10ps
module fswd_watchdog (
  input  wire logic        clk_i,                    // System clock, 10 MHz
  input  wire logic        rst_n_i,                  // Synchronous reset, active low
  input  wire logic        ce_i,                     // Clock enable, freezes all state
  input  wire logic        service_i,                // Service instruction strobe
  input  wire logic        watchdog_disable_instr_i, // Disable instruction strobe
  input  wire logic        watchdog_enable_instr_i,  // Enable instruction strobe
  input  wire logic        reload_we_i,              // Load new reload value and factor
  input  wire logic [15:0] watchdog_reload_value_i,  // New reload value
  input  wire logic        prescale_sel_i,           // New factor, 1 selects divide by 256
  output logic             enabled_o,                // Watchdog running
  output logic [15:0]      count_o,                  // Current counter value
  output logic             prewarn_irq_o,            // Prewarning interrupt, one-cycle pulse
  output logic             reset_req_o               // Reset request, held until reset
);
  logic [15:0]           reload_reg;
  logic                  sel_reg;
  logic                  en_reg;
  logic [15:0]           cnt_reg;
  logic                  prewarn_reg;
  logic                  rstreq_reg;
  logic                  overflow;
  fswd_pkg::fswd_state_e state_reg;
  fswd_tick_if           tk ();

  // ==========================================================
  // Prescaler
  assign tk.run   = ce_i && en_reg;                 // [R12]
  assign tk.clear = ce_i && en_reg && service_i;    // [R7]
  assign tk.sel   = sel_reg;

  fswd_prescaler u_pre (
    .clk_i   (clk_i),
    .rst_n_i (rst_n_i),
    .tk      (tk)
  );

  // ==========================================================
  // Reload value and prescaler factor
  always_ff @(posedge clk_i) begin
    if (!rst_n_i) begin
      reload_reg <= fswd_pkg::RELOAD_RST; // [R10]
      sel_reg    <= fswd_pkg::SEL_RST;    // [R10]
    end else if (ce_i && reload_we_i) begin
      reload_reg <= watchdog_reload_value_i; // [R6]
      sel_reg    <= prescale_sel_i;          // [R8] [R9]
    end
  end

  // ==========================================================
  // Enable state, disable wins a tie
  always_ff @(posedge clk_i) begin
    if (!rst_n_i) begin
      en_reg <= 1'b1; // [R1]
    end else if (ce_i) begin
      if (watchdog_disable_instr_i) begin
        en_reg <= 1'b0; // [R2]
      end else if (watchdog_enable_instr_i) begin
        en_reg <= 1'b1; // [R2]
      end
    end
  end

  // ==========================================================
  // Counter
  assign overflow = tk.tick && !service_i && (cnt_reg == fswd_pkg::CNT_MAX); // [R11]

  always_ff @(posedge clk_i) begin
    if (!rst_n_i) begin
      cnt_reg <= fswd_pkg::RELOAD_RST; // [R1]
    end else if (ce_i && en_reg) begin
      if (service_i || overflow) begin
        cnt_reg <= reload_reg; // [R7] [R6]
      end else if (tk.tick) begin
        cnt_reg <= cnt_reg + 16'h0001; // [R11]
      end
    end
  end

  // ==========================================================
  // Failure response: first overflow warns, second requests reset
  always_ff @(posedge clk_i) begin
    if (!rst_n_i) begin
      state_reg   <= fswd_pkg::FSWD_RUN;
      prewarn_reg <= 1'b0;
      rstreq_reg  <= 1'b0;
    end else if (ce_i) begin
      prewarn_reg <= 1'b0;
      unique case (state_reg)
        fswd_pkg::FSWD_RUN: begin
          if (en_reg && overflow) begin
            state_reg   <= fswd_pkg::FSWD_PREWARN; // [R4]
            prewarn_reg <= 1'b1;                   // [R4]
          end
        end
        fswd_pkg::FSWD_PREWARN: begin
          if (en_reg && overflow) begin
            state_reg  <= fswd_pkg::FSWD_RESET; // [R4]
            rstreq_reg <= 1'b1;                 // [R4]
          end
        end
        fswd_pkg::FSWD_RESET: begin
          rstreq_reg <= 1'b1;
        end
        default: begin
          state_reg <= fswd_pkg::FSWD_RESET;
        end
      endcase
    end
  end

  assign enabled_o     = en_reg;
  assign count_o       = cnt_reg;
  assign prewarn_irq_o = prewarn_reg;
  assign reset_req_o   = rstreq_reg;

  // ==========================================================
  // Checks
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (!rst_n_i);

  sequence s_warned;
    prewarn_irq_o ##1 !prewarn_irq_o;
  endsequence

  sequence s_overflow_in_run;
    ce_i && en_reg && overflow && state_reg == fswd_pkg::FSWD_RUN;
  endsequence

  reset_enables_a: assert property ($past(!rst_n_i)
                                    |-> en_reg && cnt_reg == fswd_pkg::RELOAD_RST) // [R1]
    else $error("watchdog not enabled after reset");
  disable_stops_a: assert property (ce_i && watchdog_disable_instr_i |=> !en_reg) // [R2]
    else $error("disable instruction ignored");
  enable_starts_a: assert property (ce_i && watchdog_enable_instr_i && !watchdog_disable_instr_i
                                    |=> en_reg) // [R2]
    else $error("enable instruction ignored");
  warn_then_reset_a: assert property ($rose(reset_req_o) |-> $past(state_reg)
                                      == fswd_pkg::FSWD_PREWARN) // [R4]
    else $error("reset request without prior prewarning");
  overflow_warns_a: assert property (s_overflow_in_run |=> s_warned) // [R4]
    else $error("prewarning pulse missing after overflow");
  service_reload_a: assert property (ce_i && en_reg && service_i
                                     |=> cnt_reg == $past(reload_reg) && tk.count == '0) // [R7]
    else $error("service did not reload counter and clear prescaler");
  wrap_reload_a: assert property (ce_i && en_reg && overflow
                                  |=> cnt_reg == $past(reload_reg)) // [R6]
    else $error("overflow did not reload counter");
  count_up_a: assert property (ce_i && en_reg && tk.tick && !service_i
                               && cnt_reg != fswd_pkg::CNT_MAX
                               |=> cnt_reg == $past(cnt_reg) + 16'h0001) // [R11]
    else $error("counter did not advance on tick");
  hold_disabled_a: assert property (!en_reg && ce_i |=> $stable(cnt_reg) && $stable(tk.count)
                                    && !prewarn_irq_o) // [R12]
    else $error("disabled watchdog changed state");
  tick_period_a: assert property (ce_i && en_reg && !service_i && !reload_we_i
                                  && sel_reg == fswd_pkg::SEL_FAST && tk.count == '0
                                  ##1 (ce_i && en_reg && !service_i && !reload_we_i)[*8]
                                  |-> tk.count == 14'h0008) // [R5]
    else $error("prescaler not counting one per cycle");

  // ==========================================================
  // Tick spacing against the selected factor
  logic [fswd_pkg::PRE_W-1:0] gap_reg;
  logic [fswd_pkg::PRE_W-1:0] gap_last;
  logic                       sel_same_reg;

  assign gap_last = (sel_reg == fswd_pkg::SEL_FAST) ?
                    fswd_pkg::PRE_W'(fswd_pkg::DIV_FAST - 1) :
                    fswd_pkg::PRE_W'(fswd_pkg::DIV_SLOW - 1);

  // Cycles since the interval began
  always_ff @(posedge clk_i) begin
    if (!rst_n_i) begin
      gap_reg <= '0;
    end else if (ce_i) begin
      if (tk.clear || tk.tick) begin
        gap_reg <= '0;
      end else if (tk.run) begin
        gap_reg <= gap_reg + 1'b1;
      end
    end
  end

  // Interval ran wholly under one factor
  always_ff @(posedge clk_i) begin
    if (!rst_n_i) begin
      sel_same_reg <= 1'b1;
    end else if (ce_i) begin
      if (tk.clear || tk.tick) begin
        sel_same_reg <= 1'b1;
      end else if (reload_we_i && (prescale_sel_i != sel_reg)) begin
        sel_same_reg <= 1'b0;
      end
    end
  end

  tick_spacing_a: assert property (tk.tick && sel_same_reg |-> gap_reg == gap_last) // [R5]
    else $error("prescaler tick at wrong spacing");
  freeze_ce_a: assert property (!ce_i |=> $stable(cnt_reg) && $stable(en_reg)
                                && $stable(tk.count) && $stable(state_reg)) // [R12]
    else $error("state changed while clock enable low");
  reset_held_a: assert property (reset_req_o |=> reset_req_o) // [R4]
    else $error("reset request dropped before reset");
  quiet_disabled_a: assert property (!en_reg && !reset_req_o |=> !reset_req_o) // [R12]
    else $error("reset request while disabled");
endmodule

/* File: verification/fail_safe_watchdog_timer_tb.sv */
// Self-checking bench of the fail-safe watchdog timer
`timescale 1ns/10ps
module fail_safe_watchdog_timer_tb;
  // ==========================================================
  // Stimulus, observation and counters
  logic        clk_i;
  logic        rst_n_i;
  logic        ce_i;
  logic        service_i;
  logic        dis_i;
  logic        en_i;
  logic        reload_we_i;
  logic [15:0] reload_i;
  logic        sel_i;
  logic        enabled_o;
  logic [15:0] count_o;
  logic        prewarn_irq_o;
  logic        reset_req_o;
  logic [15:0] held;
  int          err_total;
  int          checks_done;
  int          pw_seen;
  int          pw_base;

  fswd_watchdog dut_u (
    .clk_i                    (clk_i),
    .rst_n_i                  (rst_n_i),
    .ce_i                     (ce_i),
    .service_i                (service_i),
    .watchdog_disable_instr_i (dis_i),
    .watchdog_enable_instr_i  (en_i),
    .reload_we_i              (reload_we_i),
    .watchdog_reload_value_i  (reload_i),
    .prescale_sel_i           (sel_i),
    .enabled_o                (enabled_o),
    .count_o                  (count_o),
    .prewarn_irq_o            (prewarn_irq_o),
    .reset_req_o              (reset_req_o)
  );

  initial begin
    clk_i = 1'b0;
    forever #50 clk_i = ~clk_i;
  end

  // Counts prewarning pulses
  always @(posedge clk_i) begin
    if (prewarn_irq_o === 1'b1) pw_seen <= pw_seen + 1;
  end

  // ==========================================================
  // Shared tasks
  task automatic check(input string what, input logic [15:0] seen, input logic [15:0] exp);
    checks_done++;
    if (seen !== exp) begin
      err_total++;
      $display("mismatch %s expected %h seen %h", what, exp, seen);
    end
  endtask

  task automatic tick(input int n);
    repeat (n) @(posedge clk_i);
    #1;
  endtask

  // One-cycle strobes; returns just after the edge that takes them
  task automatic pulse(input logic s, input logic d, input logic e, input logic w);
    @(posedge clk_i);
    service_i   <= s;
    dis_i       <= d;
    en_i        <= e;
    reload_we_i <= w;
    @(posedge clk_i);
    service_i   <= 1'b0;
    dis_i       <= 1'b0;
    en_i        <= 1'b0;
    reload_we_i <= 1'b0;
    #1;
  endtask

  task automatic do_reset();
    @(posedge clk_i);
    rst_n_i <= 1'b0;
    repeat (2) @(posedge clk_i);
    rst_n_i <= 1'b1;
    tick(1);
  endtask

  task automatic setup(input logic [15:0] val, input logic sel);
    @(posedge clk_i);
    reload_i <= val;
    sel_i    <= sel;
    pulse(1'b0, 1'b0, 1'b0, 1'b1);
    pulse(1'b1, 1'b0, 1'b0, 1'b0);
    pw_base = pw_seen;
  endtask

  task automatic conclude();
    $display("checks %0d mismatches %0d", checks_done, err_total);
    if (err_total == 0 && checks_done > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask

  // ==========================================================
  // Scenarios
  task automatic t_reset();
    check("enabled", 16'(enabled_o), 16'h0001);
    check("count", count_o, 16'hff00);
    tick(250);
    check("count early", count_o, 16'hff00);
    tick(10);
    check("count one tick", count_o, 16'hff01);
    $display("test reset done");
  endtask

  task automatic t_overflow();
    setup(16'hffff, 1'b1);
    check("count reloaded", count_o, 16'hffff);
    tick(255);
    check("no early prewarn", 16'(prewarn_irq_o), 16'h0000);
    tick(1);
    check("prewarn", 16'(prewarn_irq_o), 16'h0001);
    check("count wrapped", count_o, 16'hffff);
    tick(1);
    check("prewarn one cycle", 16'(prewarn_irq_o), 16'h0000);
    tick(254);
    check("no early reset", 16'(reset_req_o), 16'h0000);
    tick(1);
    check("reset request", 16'(reset_req_o), 16'h0001);
    pulse(1'b1, 1'b0, 1'b0, 1'b0);
    tick(20);
    check("reset held", 16'(reset_req_o), 16'h0001);
    do_reset();
    check("reset cleared", 16'(reset_req_o), 16'h0000);
    check("enabled again", 16'(enabled_o), 16'h0001);
    $display("test overflow done");
  endtask

  task automatic t_disable();
    setup(16'hffff, 1'b1);
    pulse(1'b0, 1'b1, 1'b0, 1'b0);
    check("disabled", 16'(enabled_o), 16'h0000);
    held = count_o;
    tick(600);
    check("count held", count_o, held);
    check("no prewarn", 16'(pw_seen - pw_base), 16'h0000);
    pulse(1'b0, 1'b1, 1'b1, 1'b0);
    check("disable wins", 16'(enabled_o), 16'h0000);
    pulse(1'b0, 1'b0, 1'b1, 1'b0);
    check("enabled", 16'(enabled_o), 16'h0001);
    tick(300);
    check("prewarn after enable", 16'(pw_seen - pw_base), 16'h0001);
    do_reset();
    $display("test disable done");
  endtask

  task automatic t_slow();
    setup(16'hffff, 1'b0);
    tick(300);
    check("no fast tick", 16'(pw_seen - pw_base), 16'h0000);
    tick(16100);
    check("slow overflow", 16'(pw_seen - pw_base), 16'h0001);
    do_reset();
    $display("test slow done");
  endtask

  task automatic t_freeze();
    setup(16'hfff0, 1'b1);
    @(posedge clk_i);
    ce_i <= 1'b0;
    #1;
    held = count_o;
    tick(400);
    pulse(1'b1, 1'b0, 1'b0, 1'b0);
    tick(200);
    check("frozen count", count_o, held);
    check("frozen no prewarn", 16'(pw_seen - pw_base), 16'h0000);
    @(posedge clk_i);
    ce_i <= 1'b1;
    tick(300);
    check("resumed count", count_o, held + 16'h0001);
    $display("test freeze done");
  endtask

  task automatic t_service();
    setup(16'hffff, 1'b1);
    repeat (10) begin
      tick(200);
      pulse(1'b1, 1'b0, 1'b0, 1'b0);
    end
    check("serviced no prewarn", 16'(pw_seen - pw_base), 16'h0000);
    check("serviced no reset", 16'(reset_req_o), 16'h0000);
    $display("test service done");
  endtask

  // ==========================================================
  // Main sequence and hang guard
  initial begin
    err_total = 0;
    checks_done = 0;
    pw_seen = 0;
    pw_base = 0;
    rst_n_i = 1'b0;
    ce_i = 1'b1;
    service_i = 1'b0;
    dis_i = 1'b0;
    en_i = 1'b0;
    reload_we_i = 1'b0;
    reload_i = 16'h0000;
    sel_i = 1'b1;
    repeat (2) @(posedge clk_i);
    rst_n_i <= 1'b1;
    tick(1);
    t_reset();
    t_overflow();
    t_disable();
    t_slow();
    t_freeze();
    t_service();
    conclude();
  end

  initial begin
    repeat (60000) @(posedge clk_i);
    err_total++;
    conclude();
  end
endmodule
